//--- core/epv_core.v
`timescale 1ns/1ps
`include "epv_regs.vh"

// Function
// - rank reset, interrupt, direct transition, trap
// - reset starts on pin rise or watchdog
// - interrupts taken only at boundaries or at the end of a sequence
// - no sampling after control writes or reset
// - sleep direct transition starts its handling
// - trap always accepted while executing program
// - slot at vector times two or four
// - reset uses vector zero
// - reserved vector numbers never emitted
// - sleep direct transition uses vector six
// - nonmaskable interrupt uses vector seven
// - four traps use vectors eight to eleven
// - clock switchover transition uses vector twelve
// - request lines 0-7 use 16-23
// - request lines 8-15 use 56-63
// - key inputs share vectors 30 and 31
// - wake-up inputs share vector 33
// - peripheral vectors stay in three ranges
// - mode 2 advanced, mode 3 normal addressing
// - reset inits, sets mask, loads vector
// - push program counter and flags, then vector
// - trap field selects one of four vectors
// - all interrupts held off right after reset
module epv_core (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // pins
  input wire external_reset_input_n_i,
  input wire mode_advanced_i,
  // watchdog
  input wire wdt_overflow_i,
  // instruction sequencer
  input wire insn_boundary_i,
  input wire and_to_control_instruction_i,
  input wire or_to_control_instruction_i,
  input wire xor_to_control_instruction_i,
  input wire load_control_instruction_i,
  input wire sleep_direct_i,
  input wire sleep_clk_switch_i,
  input wire software_trap_instruction_i,
  input wire [1:0] trap_field_i,
  input wire condition_code_register_imask_i,
  input wire stack_push_done_i,
  input wire vec_read_done_i,
  // interrupt controller
  input wire nmi_req_i,
  input wire [15:0] maskable_external_request_lines_i,
  input wire [9:0] key_input_requests_i,
  input wire [7:0] wakeup_event_requests_i,
  input wire periph_req_i,
  input wire [6:0] periph_vec_i,
  // exception sequence
  output wire exc_busy_o,
  output wire exc_start_o,
  output wire [1:0] exc_class_o,
  output wire [6:0] vec_num_o,
  output wire [23:0] vec_addr_o,
  output wire cpu_init_o,
  output wire imask_set_o,
  output wire stack_push_req_o,
  output wire vec_read_req_o,
  output wire pc_load_o,
  output wire int_ack_o
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam ST_RST_HOLD = 3'h0;
  localparam ST_RUN = 3'h1;
  localparam ST_PUSH = 3'h2;
  localparam ST_VEC = 3'h3;
  localparam ST_EVAL = 3'h4;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function vec_reserved;
    input [6:0] v;
    begin
      vec_reserved = ((v >= `EPV_VEC_RSV1_LO) && (v <= `EPV_VEC_RSV1_HI)) ||
                     ((v >= `EPV_VEC_RSV2_LO) && (v <= `EPV_VEC_RSV2_HI)) ||
                     (v == `EPV_VEC_RSV3) || (v > `EPV_VEC_PER3_HI);
    end
  endfunction

  function [23:0] slot_addr;
    input [6:0] v;
    input adv;
    begin
      if (adv)
        slot_addr = {17'h00000, v} << `EPV_SLOT_SHIFT_ADV;
      else
        slot_addr = {17'h00000, v} << `EPV_SLOT_SHIFT_NORMAL;
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg rst_pin_meta_reg;
  reg rst_pin_sync_reg;
  reg mode_meta_reg;
  reg mode_sync_reg;

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_pin_meta_reg <= 1'b0;
      rst_pin_sync_reg <= 1'b0;
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end
    else
    begin
      rst_pin_meta_reg <= external_reset_input_n_i;
      rst_pin_sync_reg <= rst_pin_meta_reg;
      mode_meta_reg <= mode_advanced_i;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt source ranking
  // ----------------------------------------------------------------------
  wire arb_valid;
  wire [6:0] arb_vec;

  epv_int_arb u_arb (
    .nmi_req_i(nmi_req_i),
    .maskable_external_request_lines_i(maskable_external_request_lines_i),
    .key_input_requests_i(key_input_requests_i),
    .wakeup_event_requests_i(wakeup_event_requests_i),
    .periph_req_i(periph_req_i),
    .periph_vec_i(periph_vec_i),
    .imask_i(condition_code_register_imask_i),
    .req_valid_o(arb_valid),
    .req_vec_o(arb_vec)
  );

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg direct_pend_reg;
  reg direct_pend_next;
  reg direct_clksw_reg;
  reg direct_clksw_next;
  reg trap_pend_reg;
  reg trap_pend_next;
  reg [1:0] trap_sel_reg;
  reg [1:0] trap_sel_next;
  reg [1:0] class_reg;
  reg [1:0] class_next;
  reg [6:0] vec_reg;
  reg [6:0] vec_next;
  reg [23:0] addr_reg;
  reg [23:0] addr_next;
  reg busy_reg;
  reg busy_next;
  reg start_reg;
  reg start_next;
  reg init_reg;
  reg init_next;
  reg imask_set_reg;
  reg imask_set_next;
  reg push_req_reg;
  reg push_req_next;
  reg read_req_reg;
  reg read_req_next;
  reg pc_load_reg;
  reg pc_load_next;
  reg ack_reg;
  reg ack_next;

  // ----------------------------------------------------------------------
  // acceptance decision
  // ----------------------------------------------------------------------
  wire rst_event;
  wire ctl_write_insn;
  wire direct_live;
  wire trap_live;
  reg allow_int;
  reg take;
  reg [1:0] take_class;
  reg [6:0] take_vec;

  // the watchdog restarts the reset sequence even while the pin stays high
  assign rst_event = wdt_overflow_i | ~rst_pin_sync_reg;
  assign ctl_write_insn = and_to_control_instruction_i | or_to_control_instruction_i |
                          xor_to_control_instruction_i | load_control_instruction_i;
  // a sleep or trap pulse that ends its own instruction is handled at that same boundary unless a higher-ranked event is taken there
  assign direct_live = (state_reg == ST_RUN) & sleep_direct_i;
  assign trap_live = (state_reg == ST_RUN) & software_trap_instruction_i;

  always @*
  begin
    allow_int = 1'b0;
    if (state_reg == ST_RUN)
      allow_int = insn_boundary_i & ~ctl_write_insn;
    else if (state_reg == ST_EVAL)
      allow_int = 1'b1;
    take = 1'b0;
    take_class = `EPV_CLASS_INT;
    take_vec = `EPV_VEC_RESET;
    // order of tests is the priority; losers keep their pending state
    if (allow_int && arb_valid && !vec_reserved(arb_vec))
    begin
      take = 1'b1;
      take_class = `EPV_CLASS_INT;
      take_vec = arb_vec;
    end
    else if (direct_pend_reg || direct_live)
    begin
      take = 1'b1;
      take_class = `EPV_CLASS_DIRECT;
      if (direct_live)
        take_vec = sleep_clk_switch_i ? `EPV_VEC_CLKSW : `EPV_VEC_DIRECT;
      else
        take_vec = direct_clksw_reg ? `EPV_VEC_CLKSW : `EPV_VEC_DIRECT;
    end
    else if (trap_pend_reg || trap_live)
    begin
      take = 1'b1;
      take_class = `EPV_CLASS_TRAP;
      take_vec = `EPV_VEC_TRAP_BASE + {5'h00, (trap_live ? trap_field_i : trap_sel_reg)};
    end
    // decisions only happen at a boundary or at the end of a sequence
    if ((state_reg == ST_RUN) && !insn_boundary_i)
      take = 1'b0;
    if ((state_reg != ST_RUN) && (state_reg != ST_EVAL))
      take = 1'b0;
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    direct_pend_next = direct_pend_reg;
    direct_clksw_next = direct_clksw_reg;
    trap_pend_next = trap_pend_reg;
    trap_sel_next = trap_sel_reg;
    class_next = class_reg;
    vec_next = vec_reg;
    addr_next = addr_reg;
    busy_next = busy_reg;
    start_next = 1'b0;
    init_next = init_reg;
    imask_set_next = 1'b0;
    push_req_next = push_req_reg;
    read_req_next = read_req_reg;
    pc_load_next = 1'b0;
    ack_next = 1'b0;

    // a taken pending event is cleared; a live pulse is latched whenever it is not taken (it loses, or no boundary)
    if (take && (take_class == `EPV_CLASS_DIRECT) && !direct_live)
      direct_pend_next = 1'b0;
    if (take && (take_class == `EPV_CLASS_TRAP) && !trap_live)
      trap_pend_next = 1'b0;
    if (direct_live && !(take && (take_class == `EPV_CLASS_DIRECT)))
    begin
      direct_pend_next = 1'b1;
      direct_clksw_next = sleep_clk_switch_i;
    end
    if (trap_live && !(take && (take_class == `EPV_CLASS_TRAP)))
    begin
      trap_pend_next = 1'b1;
      trap_sel_next = trap_field_i;
    end

    case (state_reg)
      ST_RST_HOLD:
      begin
        init_next = 1'b1;
        busy_next = 1'b1;
        if (rst_pin_sync_reg)
        begin
          state_next = ST_VEC;
          class_next = `EPV_CLASS_RESET;
          vec_next = `EPV_VEC_RESET;
          addr_next = slot_addr(`EPV_VEC_RESET, mode_sync_reg);
          init_next = 1'b0;
          imask_set_next = 1'b1;
          read_req_next = 1'b1;
          start_next = 1'b1;
        end
      end
      ST_RUN, ST_EVAL:
      begin
        if (take)
        begin
          state_next = ST_PUSH;
          class_next = take_class;
          vec_next = take_vec;
          addr_next = slot_addr(take_vec, mode_sync_reg);
          busy_next = 1'b1;
          start_next = 1'b1;
          push_req_next = 1'b1;
          ack_next = (take_class == `EPV_CLASS_INT);
        end
        else
        begin
          state_next = ST_RUN;
          busy_next = 1'b0;
        end
      end
      ST_PUSH:
      begin
        if (stack_push_done_i)
        begin
          state_next = ST_VEC;
          push_req_next = 1'b0;
          read_req_next = 1'b1;
        end
      end
      ST_VEC:
      begin
        if (vec_read_done_i)
        begin
          read_req_next = 1'b0;
          pc_load_next = 1'b1;
          // after reset the first instruction runs before any sampling
          if (class_reg == `EPV_CLASS_RESET)
          begin
            state_next = ST_RUN;
            busy_next = 1'b0;
          end
          else
            state_next = ST_EVAL;
        end
      end
      default:
      begin
        state_next = ST_RST_HOLD;
      end
    endcase

    // reset outranks everything and drops all pending work
    if (rst_event)
    begin
      state_next = ST_RST_HOLD;
      direct_pend_next = 1'b0;
      trap_pend_next = 1'b0;
      busy_next = 1'b1;
      init_next = 1'b1;
      start_next = 1'b0;
      imask_set_next = 1'b0;
      push_req_next = 1'b0;
      read_req_next = 1'b0;
      pc_load_next = 1'b0;
      ack_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ST_RST_HOLD;
      direct_pend_reg <= 1'b0;
      direct_clksw_reg <= 1'b0;
      trap_pend_reg <= 1'b0;
      trap_sel_reg <= 2'h0;
      class_reg <= `EPV_CLASS_RESET;
      vec_reg <= `EPV_VEC_RESET;
      addr_reg <= 24'h000000;
      busy_reg <= 1'b1;
      start_reg <= 1'b0;
      init_reg <= 1'b1;
      imask_set_reg <= 1'b0;
      push_req_reg <= 1'b0;
      read_req_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      ack_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      direct_pend_reg <= direct_pend_next;
      direct_clksw_reg <= direct_clksw_next;
      trap_pend_reg <= trap_pend_next;
      trap_sel_reg <= trap_sel_next;
      class_reg <= class_next;
      vec_reg <= vec_next;
      addr_reg <= addr_next;
      busy_reg <= busy_next;
      start_reg <= start_next;
      init_reg <= init_next;
      imask_set_reg <= imask_set_next;
      push_req_reg <= push_req_next;
      read_req_reg <= read_req_next;
      pc_load_reg <= pc_load_next;
      ack_reg <= ack_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign exc_busy_o = busy_reg;
  assign exc_start_o = start_reg;
  assign exc_class_o = class_reg;
  assign vec_num_o = vec_reg;
  assign vec_addr_o = addr_reg;
  assign cpu_init_o = init_reg;
  assign imask_set_o = imask_set_reg;
  assign stack_push_req_o = push_req_reg;
  assign vec_read_req_o = read_req_reg;
  assign pc_load_o = pc_load_reg;
  assign int_ack_o = ack_reg;

endmodule // epv_core

//--- core/epv_regs.vh
`ifndef EPV_REGS_VH
`define EPV_REGS_VH

// ----------------------------------------------------------------------
// exception classes, highest priority first
// ----------------------------------------------------------------------
`define EPV_CLASS_RESET 2'h0
`define EPV_CLASS_INT 2'h1
`define EPV_CLASS_DIRECT 2'h2
`define EPV_CLASS_TRAP 2'h3

// ----------------------------------------------------------------------
// vector numbers
// ----------------------------------------------------------------------
`define EPV_VEC_RESET 7'h00
`define EPV_VEC_RSV1_LO 7'h01
`define EPV_VEC_RSV1_HI 7'h05
`define EPV_VEC_DIRECT 7'h06
`define EPV_VEC_NMI 7'h07
`define EPV_VEC_TRAP_BASE 7'h08
`define EPV_VEC_CLKSW 7'h0C
`define EPV_VEC_RSV2_LO 7'h0D
`define EPV_VEC_RSV2_HI 7'h0F
`define EPV_VEC_IRQ_LO_BASE 7'h10
`define EPV_VEC_PER1_LO 7'h18
`define EPV_VEC_PER1_HI 7'h1D
`define EPV_VEC_KEY_LO 7'h1E
`define EPV_VEC_KEY_HI 7'h1F
`define EPV_VEC_RSV3 7'h20
`define EPV_VEC_WAKE 7'h21
`define EPV_VEC_PER2_LO 7'h22
`define EPV_VEC_PER2_HI 7'h37
`define EPV_VEC_IRQ_HI_BASE 7'h38
`define EPV_VEC_PER3_LO 7'h40
`define EPV_VEC_PER3_HI 7'h72

// ----------------------------------------------------------------------
// vector slot forming
// ----------------------------------------------------------------------
`define EPV_SLOT_SHIFT_NORMAL 2'h1
`define EPV_SLOT_SHIFT_ADV 2'h2

`endif

//--- core/epv_int_arb.v
`timescale 1ns/1ps
`include "epv_regs.vh"

module epv_int_arb (
  // request lines from the interrupt controller
  input wire nmi_req_i,
  input wire [15:0] maskable_external_request_lines_i,
  input wire [9:0] key_input_requests_i,
  input wire [7:0] wakeup_event_requests_i,
  input wire periph_req_i,
  input wire [6:0] periph_vec_i,
  // mask
  input wire imask_i,
  // result
  output reg req_valid_o,
  output reg [6:0] req_vec_o
);

  // ----------------------------------------------------------------------
  // range checks
  // ----------------------------------------------------------------------
  function periph_vec_ok;
    input [6:0] v;
    begin
      periph_vec_ok = ((v >= `EPV_VEC_PER1_LO) && (v <= `EPV_VEC_PER1_HI)) ||
                      ((v >= `EPV_VEC_PER2_LO) && (v <= `EPV_VEC_PER2_HI)) ||
                      ((v >= `EPV_VEC_PER3_LO) && (v <= `EPV_VEC_PER3_HI));
    end
  endfunction

  // ----------------------------------------------------------------------
  // fixed ranking: lower entries are written last and win
  // ----------------------------------------------------------------------
  integer i;

  always @*
  begin
    req_valid_o = 1'b0;
    req_vec_o = `EPV_VEC_RESET;
    // a peripheral number outside its ranges is dropped, never vectored
    if (periph_req_i && periph_vec_ok(periph_vec_i))
    begin
      req_valid_o = 1'b1;
      req_vec_o = periph_vec_i;
    end
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (maskable_external_request_lines_i[i + 8])
      begin
        req_valid_o = 1'b1;
        req_vec_o = `EPV_VEC_IRQ_HI_BASE + i[6:0];
      end
    end
    if (|wakeup_event_requests_i)
    begin
      req_valid_o = 1'b1;
      req_vec_o = `EPV_VEC_WAKE;
    end
    if (|key_input_requests_i[9:8])
    begin
      req_valid_o = 1'b1;
      req_vec_o = `EPV_VEC_KEY_HI;
    end
    if (|key_input_requests_i[7:0])
    begin
      req_valid_o = 1'b1;
      req_vec_o = `EPV_VEC_KEY_LO;
    end
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (maskable_external_request_lines_i[i])
      begin
        req_valid_o = 1'b1;
        req_vec_o = `EPV_VEC_IRQ_LO_BASE + i[6:0];
      end
    end
    // the interrupt mask bit holds off everything but the nonmaskable line
    if (imask_i)
    begin
      req_valid_o = 1'b0;
      req_vec_o = `EPV_VEC_RESET;
    end
    if (nmi_req_i)
    begin
      req_valid_o = 1'b1;
      req_vec_o = `EPV_VEC_NMI;
    end
  end

endmodule // epv_int_arb

//--- verif/epv_core_sva.sv
`timescale 1ns/1ps
module epv_core_sva (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // stimulus side
  input wire mode_advanced_i,
  input wire wdt_overflow_i,
  input wire insn_boundary_i,
  input wire and_to_control_instruction_i,
  input wire or_to_control_instruction_i,
  input wire xor_to_control_instruction_i,
  input wire load_control_instruction_i,
  input wire stack_push_done_i,
  input wire vec_read_done_i,
  input wire nmi_req_i,
  // exception sequence
  input wire exc_busy_o,
  input wire exc_start_o,
  input wire [1:0] exc_class_o,
  input wire [6:0] vec_num_o,
  input wire [23:0] vec_addr_o,
  input wire cpu_init_o,
  input wire imask_set_o,
  input wire stack_push_req_o,
  input wire vec_read_req_o,
  input wire pc_load_o,
  input wire int_ack_o
);
  wire any_ctl;
  assign any_ctl = and_to_control_instruction_i | or_to_control_instruction_i |
    xor_to_control_instruction_i | load_control_instruction_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  nmi_take_a: assert property (insn_boundary_i && !exc_busy_o && nmi_req_i && !wdt_overflow_i
    && !any_ctl |=> exc_start_o && exc_class_o == 2'h1 && vec_num_o == 7'h07)
    else $error("nmi not taken at boundary");
  ctl_skip_a: assert property (insn_boundary_i && !exc_busy_o && any_ctl |=> !int_ack_o)
    else $error("interrupt taken after control write");
  wdt_reset_a: assert property (wdt_overflow_i |-> ##[1:3] (cpu_init_o && exc_busy_o))
    else $error("watchdog did not reset");
  slot_addr_a: assert property (exc_start_o && mode_advanced_i == $past(mode_advanced_i, 3)
    |-> vec_addr_o == (mode_advanced_i ? {15'h0, vec_num_o, 2'h0} : {16'h0, vec_num_o, 1'h0}))
    else $error("vector slot address wrong");
  reserved_vec_a: assert property (exc_start_o |-> vec_num_o <= 7'h72 &&
    !(vec_num_o inside {[7'h01:7'h05], [7'h0D:7'h0F], 7'h20}))
    else $error("reserved vector emitted");
  reset_vec_a: assert property (exc_start_o && exc_class_o == 2'h0 |-> vec_num_o == 7'h00
    && imask_set_o && !int_ack_o) else $error("reset start wrong");
  mask_only_a: assert property (imask_set_o |-> exc_start_o && exc_class_o == 2'h0)
    else $error("mask set outside reset");
  trap_range_a: assert property (exc_start_o && exc_class_o == 2'h3 |->
    vec_num_o inside {[7'h08:7'h0B]}) else $error("trap vector out of range");
  direct_vec_a: assert property (exc_start_o && exc_class_o == 2'h2 |->
    vec_num_o == 7'h06 || vec_num_o == 7'h0C) else $error("direct vector wrong");
  push_read_a: assert property (stack_push_req_o && stack_push_done_i |=>
    !stack_push_req_o && vec_read_req_o) else $error("fetch did not follow push");
  read_load_a: assert property (vec_read_req_o && vec_read_done_i |=>
    !vec_read_req_o && pc_load_o) else $error("pc load did not follow fetch");
endmodule // epv_core_sva

bind epv_core epv_core_sva u_epv_core_sva (.*);

//--- verif/epv_seq_model.sv
`timescale 1ns/1ps
module epv_seq_model (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // requests from the unit
  input wire stack_push_req_i,
  input wire vec_read_req_i,
  input wire slow_i,
  // answers
  output reg stack_push_done_o,
  output reg vec_read_done_o
);
  reg [1:0] cnt_reg;
  // answers change on the falling edge so the unit samples them settled
  always @(negedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_reg <= 2'h0;
      stack_push_done_o <= 1'h0;
      vec_read_done_o <= 1'h0;
    end
    else
    begin
      stack_push_done_o <= 1'h0;
      vec_read_done_o <= 1'h0;
      if ((stack_push_req_i || vec_read_req_i) && !stack_push_done_o && !vec_read_done_o)
      begin
        if (cnt_reg >= (slow_i ? 2'h3 : 2'h0))
        begin
          cnt_reg <= 2'h0;
          stack_push_done_o <= stack_push_req_i;
          vec_read_done_o <= vec_read_req_i;
        end
        else
          cnt_reg <= cnt_reg + 2'h1;
      end
      else
        cnt_reg <= 2'h0;
    end
  end
endmodule // epv_seq_model

//--- verif/exception_priority_vectoring_test.sv
`timescale 1ns/1ps
module exception_priority_vectoring_test;
  reg clk_sys_i = 1'h0;
  reg reset_n_i = 1'h0;
  reg pin_n = 1'h1;
  reg adv = 1'h0;
  reg wdt = 1'h0;
  reg bnd = 1'h0;
  reg [3:0] ctl = 4'h0;
  reg slp = 1'h0;
  reg slp_sw = 1'h0;
  reg trp = 1'h0;
  reg [1:0] tfld = 2'h0;
  reg imask = 1'h0;
  reg nmi = 1'h0;
  reg [15:0] irq = 16'h0;
  reg [9:0] key = 10'h0;
  reg [7:0] wake = 8'h0;
  reg preq = 1'h0;
  reg [6:0] pvec = 7'h00;
  reg slow = 1'h0;
  wire pdone, rdone, busy, start, init, iset, preq_o, rreq, pcl, ack;
  wire [1:0] cls;
  wire [6:0] vnum;
  wire [23:0] vaddr;
  integer n_fail = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer k;

  always #12.5 clk_sys_i = ~clk_sys_i;

  epv_core u_epv_core (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .external_reset_input_n_i(pin_n), .mode_advanced_i(adv),
    .wdt_overflow_i(wdt), .insn_boundary_i(bnd),
    .and_to_control_instruction_i(ctl[0]), .or_to_control_instruction_i(ctl[1]),
    .xor_to_control_instruction_i(ctl[2]), .load_control_instruction_i(ctl[3]),
    .sleep_direct_i(slp), .sleep_clk_switch_i(slp_sw),
    .software_trap_instruction_i(trp), .trap_field_i(tfld),
    .condition_code_register_imask_i(imask),
    .stack_push_done_i(pdone), .vec_read_done_i(rdone),
    .nmi_req_i(nmi), .maskable_external_request_lines_i(irq),
    .key_input_requests_i(key), .wakeup_event_requests_i(wake),
    .periph_req_i(preq), .periph_vec_i(pvec),
    .exc_busy_o(busy), .exc_start_o(start), .exc_class_o(cls),
    .vec_num_o(vnum), .vec_addr_o(vaddr), .cpu_init_o(init),
    .imask_set_o(iset), .stack_push_req_o(preq_o), .vec_read_req_o(rreq),
    .pc_load_o(pcl), .int_ack_o(ack));

  epv_seq_model u_epv_seq_model (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .stack_push_req_i(preq_o), .vec_read_req_i(rreq), .slow_i(slow),
    .stack_push_done_o(pdone), .vec_read_done_o(rdone));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task wrap_up;
  begin
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  task check(input [31:0] got, input [31:0] exp, input string what);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("Error %0s expected %0h seen %0h", what, exp, got);
    end
  end
  endtask

  // bounded wait; consumes the start cycle so a following start is seen fresh
  task wait_start(input [1:0] c, input [6:0] v);
    integer i;
  begin
    i = 0;
    while (start !== 1'h1 && i < 60)
    begin
      @(negedge clk_sys_i);
      i = i + 1;
    end
    check(start, 1, "start");
    check(cls, c, "class");
    check(vnum, v, "vector");
    check(vaddr, adv ? {15'h0, v, 2'h0} : {16'h0, v, 1'h0}, "address");
    check(ack, c == 2'h1, "ack");
    check(iset, c == 2'h0, "mask set");
    @(negedge clk_sys_i);
  end
  endtask

  task idle;
    integer i;
  begin
    i = 0;
    while (busy !== 1'h0 && i < 80)
    begin
      @(negedge clk_sys_i);
      i = i + 1;
    end
    check(busy, 0, "idle");
  end
  endtask

  task boundary(input [3:0] q);
  begin
    bnd = 1'h1;
    ctl = q;
    @(negedge clk_sys_i);
    bnd = 1'h0;
    ctl = 4'h0;
    trp = 1'h0;
    slp = 1'h0;
  end
  endtask

  task quiet(input integer n);
  begin
    repeat (n)
    begin
      check(start, 0, "no start");
      @(negedge clk_sys_i);
    end
  end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task s_reset;
  begin
    nmi = 1'h1;
    repeat (5) @(negedge clk_sys_i);
    reset_n_i = 1'h1;
    wait_start(2'h0, 7'h00);
    idle;
    quiet(4);
    boundary(4'h0);
    wait_start(2'h1, 7'h07);
    nmi = 1'h0;
    idle;
  end
  endtask

  task s_trap_direct;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      tfld = k;
      trp = 1'h1;
      boundary(4'h0);
      wait_start(2'h3, 7'h08 + k);
      idle;
    end
    for (k = 0; k < 2; k = k + 1)
    begin
      slp = 1'h1;
      slp_sw = k;
      boundary(4'h0);
      wait_start(2'h2, k ? 7'h0C : 7'h06);
      idle;
    end
  end
  endtask

  task s_sources;
  begin
    for (k = 0; k < 16; k = k + 1)
    begin
      irq = 16'h1 << k;
      boundary(4'h0);
      wait_start(2'h1, k < 8 ? 7'h10 + k : 7'h30 + k);
      irq = 16'h0;
      idle;
    end
    for (k = 0; k < 5; k = k + 1)
    begin
      key = k == 0 ? 10'h001 : k == 1 ? 10'h200 : 10'h000;
      wake = k == 2 ? 8'h08 : 8'h00;
      preq = k > 2;
      pvec = k == 3 ? 7'h18 : 7'h72;
      boundary(4'h0);
      wait_start(2'h1, k == 0 ? 7'h1E : k == 1 ? 7'h1F : k == 2 ? 7'h21 : pvec);
      key = 10'h000;
      wake = 8'h00;
      preq = 1'h0;
      idle;
    end
    preq = 1'h1;
    pvec = 7'h20;
    boundary(4'h0);
    quiet(4);
    preq = 1'h0;
  end
  endtask

  task s_mask;
  begin
    irq = 16'h0001;
    quiet(5);
    imask = 1'h1;
    boundary(4'h0);
    quiet(3);
    imask = 1'h0;
    for (k = 0; k < 4; k = k + 1)
    begin
      boundary(4'h1 << k);
      quiet(2);
    end
    boundary(4'h0);
    wait_start(2'h1, 7'h10);
    irq = 16'h0;
    idle;
    imask = 1'h1;
    nmi = 1'h1;
    boundary(4'h0);
    wait_start(2'h1, 7'h07);
    nmi = 1'h0;
    imask = 1'h0;
    idle;
  end
  endtask

  task s_prio;
  begin
    slow = 1'h1;
    nmi = 1'h1;
    irq = 16'h0008;
    slp = 1'h1;
    slp_sw = 1'h0;
    trp = 1'h1;
    tfld = 2'h0;
    boundary(4'h0);
    wait_start(2'h1, 7'h07);
    nmi = 1'h0;
    wait_start(2'h1, 7'h13);
    irq = 16'h0;
    wait_start(2'h2, 7'h06);
    wait_start(2'h3, 7'h08);
    slow = 1'h0;
    idle;
  end
  endtask

  task s_resets;
  begin
    adv = 1'h1;
    repeat (4) @(negedge clk_sys_i);
    wdt = 1'h1;
    @(negedge clk_sys_i);
    wdt = 1'h0;
    check(init, 1, "watchdog init");
    wait_start(2'h0, 7'h00);
    idle;
    tfld = 2'h1;
    trp = 1'h1;
    boundary(4'h0);
    wait_start(2'h3, 7'h09);
    idle;
    pin_n = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    check(init, 1, "pin init");
    check(busy, 1, "pin busy");
    pin_n = 1'h1;
    wait_start(2'h0, 7'h00);
    idle;
  end
  endtask

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  // the whole run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end

  initial
  begin
    @(negedge clk_sys_i);
    s_reset;
    s_trap_direct;
    s_sources;
    s_mask;
    s_prio;
    s_resets;
    wrap_up;
  end
endmodule // exception_priority_vectoring_test
